//--- hdl/dcl_pkg.sv
// Package for the digital I/O channel block: map, reset values, timing.
// Assumes a 100 MHz clock and a 32-bit AXI4-Lite register port.
package dcl_pkg;
    localparam int NDI = 4;
    localparam int NDO = 4;
    localparam int CLK_NS = 10;

    localparam logic [7:0] A_DO = 8'h00;
    localparam logic [7:0] A_SAFE = 8'h04;
    localparam logic [7:0] A_WDT = 8'h08;
    localparam logic [7:0] A_PWM_EN = 8'h0c;
    localparam logic [7:0] A_MIRROR = 8'h10;
    localparam logic [7:0] A_PAIR = 8'h14;
    localparam logic [7:0] A_FCFG = 8'h18;
    localparam logic [7:0] A_DI = 8'h1c;
    localparam logic [7:0] A_LHI = 8'h20;
    localparam logic [7:0] A_LLO = 8'h24;
    localparam logic [7:0] A_ISTAT = 8'h28;
    localparam logic [7:0] A_IMASK = 8'h2c;
    localparam logic [7:0] A_PWM0 = 8'h40;
    localparam logic [7:0] A_CNT0 = 8'h50;
    localparam logic [7:0] A_FRQ0 = 8'h60;

    localparam logic [NDO-1:0] DO_PWRON_RST = 4'h0;
    localparam logic [NDO-1:0] SAFE_RST = 4'h0;
    localparam logic [31:0] WDT_RST = 32'h0;
    localparam logic [31:0] PWM_CFG_RST = 32'h0;

    // Pair field positions
    localparam int PAIR_EN_BIT = 0;
    localparam int PAIR_MASK_LSB = 4;
    // Frequency config field positions
    localparam int FCFG_SCAN_LSB = 0;
    localparam int FCFG_AVG_LSB = 2;

    localparam int IRQ_WDT = 0;
    localparam int IRQ_PAIR = 1;
    localparam int IRQ_FREQ = 2;
    localparam int NIRQ = 3;

    localparam int PWM_TICK_NS = 10000;
    localparam int PWM_TICK_CYC = (PWM_TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int PWM_MIN_PERIOD_NS = 10000000;
    localparam int PWM_MIN_TICKS = (PWM_MIN_PERIOD_NS + PWM_TICK_NS - 1) / PWM_TICK_NS;
    localparam int GATE_1S_NS = 1000000000;
    localparam int GATE_1S_CYC = GATE_1S_NS / CLK_NS;
    localparam int PAIR_POLL_NS = 10000000;
    localparam int PAIR_POLL_CYC = PAIR_POLL_NS / CLK_NS;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {MIR_OFF = 2'h0, MIR_LEVEL = 2'h1, MIR_RISE = 2'h2, MIR_FALL = 2'h3} dcl_mir_t;
    typedef enum logic [1:0] {PH_HI = 2'h1, PH_LO = 2'h2} dcl_phase_t;
endpackage : dcl_pkg

//--- hdl/dcl_channel_top.sv
// Digital input/output channel logic with AXI4-Lite register access.
// Assumes inputs arrive asynchronously on pins; pair answers come from
// a same-clock network client that holds pair_level valid with pair_ack.
//
// What this block does
// [R1] At boot every output sits at its power-on level before host access.
// [R2] Host silence for the set timeout forces all outputs without pulse generation enabled to safe levels.
// [R3] Every output has its own pulse generator, 100 Hz at most, independent.
// [R4] High setting is the on-time, low setting the off-time of one period.
// [R5] Each input counts its rising edges in a 32-bit counter the host reads.
// [R6] Sticky seen-high and seen-low flags keep short pulses for later reads.
// [R7] Frequency from counter samples, three scan modes, four averaging methods.
// [R8] Level mirror mode: output follows its input continuously.
// [R9] Rising mirror mode: input going on switches output on.
// [R10] Falling mirror mode: input going off switches output on.
// [R11] Pairing polls a remote input and writes it to chosen local outputs.
// [R12] Every valid host access restarts the silence timer.
// [R13] A latched-status read clears the flags it returned.
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module dcl_channel_top #(
    parameter int unsigned GATE_CYC = dcl_pkg::GATE_1S_CYC,
    parameter int unsigned PAIR_POLL_CYC = dcl_pkg::PAIR_POLL_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [dcl_pkg::NDI-1:0] di_pin,
    output logic [dcl_pkg::NDO-1:0] do_out,
    output logic pair_req,
    input wire logic pair_ack,
    input wire logic pair_level,
    output logic irq
);
    import dcl_pkg::*;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : wmerge

    function automatic logic arr_sel(input logic [7:0] a, input logic [7:0] base);
        return (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    endfunction : arr_sel

    function automatic logic [16:0] lo_len(input logic [31:0] cfg);
        logic [16:0] sum;
        sum = {1'b0, cfg[15:0]} + {1'b0, cfg[31:16]};
        // Stretch the off-time so the period never beats the rate ceiling
        if (sum < 17'(PWM_MIN_TICKS)) begin
            return 17'(PWM_MIN_TICKS) - {1'b0, cfg[15:0]};
        end
        return {1'b0, cfg[31:16]};
    endfunction : lo_len

    logic awready_reg, bvalid_reg, arready_reg, rvalid_reg, irq_reg, pair_req_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg, rd_val, wdt_to_reg, wdt_cnt_reg, gate_cnt_reg, gate_len, pair_cnt_reg;
    logic rd_ok, wr_map, wr_go, rd_go, host_msg, wdt_fire, wdt_fired_reg, pair_wait_reg, pair_hit, tick;
    logic [NDO-1:0] do_out_reg, do_base_reg, safe_reg, pwm_en_reg, pwm_lvl, pair_mask_reg;
    logic [NDI-1:0] di_meta_reg, di_s_reg, di_d_reg, lat_hi_reg, lat_lo_reg, rise, fall;
    logic [2*NDO-1:0] mirror_reg;
    logic [3:0] fcfg_reg;
    logic pair_en_reg;
    logic [NIRQ-1:0] istat_reg, imask_reg, ievt;
    logic [15:0] tick_cnt_reg;
    logic [31:0] pwm_cfg_reg [NDO];
    logic [15:0] pcnt_reg [NDO];
    dcl_phase_t ph_reg [NDO];
    logic [31:0] cnt_reg [NDI];
    logic [31:0] prev_reg [NDI];
    logic [31:0] frq_reg [NDI];

    assign awready = awready_reg;
    assign wready = awready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign do_out = do_out_reg;
    assign pair_req = pair_req_reg;
    assign irq = irq_reg;

    // Bus slave: address and data are taken together, one cycle after both show
    assign wr_go = ce && awready_reg && awvalid && wvalid;
    assign rd_go = ce && arready_reg && arvalid;
    assign host_msg = wr_go || rd_go;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (ce) begin
            awready_reg <= !awready_reg && !bvalid_reg && awvalid && wvalid;
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (ce) begin
            arready_reg <= !arready_reg && !rvalid_reg && arvalid;
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_val;
                rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        wr_map = 1'b1;
        case (awaddr)
            A_DO, A_SAFE, A_WDT, A_PWM_EN, A_MIRROR, A_PAIR, A_FCFG, A_DI, A_LHI, A_LLO, A_ISTAT, A_IMASK: begin
                wr_map = 1'b1;
            end
            default: begin
                wr_map = arr_sel(awaddr, A_PWM0) || arr_sel(awaddr, A_CNT0) || arr_sel(awaddr, A_FRQ0);
            end
        endcase
    end

    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        case (araddr)
            A_DO: rd_val[NDO-1:0] = do_out_reg;
            A_SAFE: rd_val[NDO-1:0] = safe_reg;
            A_WDT: rd_val = wdt_to_reg;
            A_PWM_EN: rd_val[NDO-1:0] = pwm_en_reg;
            A_MIRROR: rd_val[2*NDO-1:0] = mirror_reg;
            A_PAIR: rd_val[7:0] = {pair_mask_reg, 3'h0, pair_en_reg};
            A_FCFG: rd_val[3:0] = fcfg_reg;
            A_DI: rd_val[NDI-1:0] = di_s_reg;
            A_LHI: rd_val[NDI-1:0] = lat_hi_reg;
            A_LLO: rd_val[NDI-1:0] = lat_lo_reg;
            A_ISTAT: rd_val[NIRQ-1:0] = istat_reg;
            A_IMASK: rd_val[NIRQ-1:0] = imask_reg;
            default: begin
                if (arr_sel(araddr, A_PWM0)) begin
                    rd_val = pwm_cfg_reg[araddr[3:2]];
                end else if (arr_sel(araddr, A_CNT0)) begin
                    rd_val = cnt_reg[araddr[3:2]];
                end else if (arr_sel(araddr, A_FRQ0)) begin
                    rd_val = frq_reg[araddr[3:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            safe_reg <= SAFE_RST;
            wdt_to_reg <= WDT_RST;
            pwm_en_reg <= '0;
            mirror_reg <= '0;
            pair_en_reg <= 1'b0;
            pair_mask_reg <= '0;
            fcfg_reg <= 4'h0;
            imask_reg <= '0;
            for (int i = 0; i < NDO; i++) begin
                pwm_cfg_reg[i] <= PWM_CFG_RST;
            end
        end else if (ce && wr_go) begin
            if (awaddr == A_SAFE && wstrb[0]) safe_reg <= wdata[NDO-1:0];
            if (awaddr == A_WDT) wdt_to_reg <= wmerge(wdt_to_reg, wdata, wstrb);
            if (awaddr == A_PWM_EN && wstrb[0]) pwm_en_reg <= wdata[NDO-1:0];
            if (awaddr == A_MIRROR && wstrb[0]) mirror_reg <= wdata[2*NDO-1:0];
            if (awaddr == A_PAIR && wstrb[0]) begin
                pair_en_reg <= wdata[PAIR_EN_BIT];
                pair_mask_reg <= wdata[PAIR_MASK_LSB +: NDO];
            end
            if (awaddr == A_FCFG && wstrb[0]) fcfg_reg <= wdata[3:0];
            if (awaddr == A_IMASK && wstrb[0]) imask_reg <= wdata[NIRQ-1:0];
            if (arr_sel(awaddr, A_PWM0)) begin
                pwm_cfg_reg[awaddr[3:2]] <= wmerge(pwm_cfg_reg[awaddr[3:2]], wdata, wstrb); // see [R3]
            end
        end
    end

    // Input synchroniser; only the second and third stages feed logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            di_meta_reg <= '0;
            di_s_reg <= '0;
            di_d_reg <= '0;
        end else if (ce) begin
            di_meta_reg <= di_pin;
            di_s_reg <= di_meta_reg;
            di_d_reg <= di_s_reg;
        end
    end
    assign rise = di_s_reg & ~di_d_reg;
    assign fall = ~di_s_reg & di_d_reg;

    // Sticky flags; a new level in the clearing cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_hi_reg <= '0;
            lat_lo_reg <= '0;
        end else if (ce) begin
            lat_hi_reg <= (rd_go && araddr == A_LHI) ? di_s_reg : (lat_hi_reg | di_s_reg); // see [R6] see [R13]
            lat_lo_reg <= (rd_go && araddr == A_LLO) ? ~di_s_reg : (lat_lo_reg | ~di_s_reg); // see [R6] see [R13]
        end
    end

    // Transition counters count rising edges, one per pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NDI; i++) cnt_reg[i] <= 32'h0;
        end else if (ce) begin
            for (int i = 0; i < NDI; i++) begin
                if (rise[i]) cnt_reg[i] <= cnt_reg[i] + 32'h1; // see [R5]
            end
        end
    end

    // Frequency: gate 1 s, 100 ms or 10 ms, scaled to events per second
    always_comb begin
        case (fcfg_reg[FCFG_SCAN_LSB +: 2])
            2'h1: gate_len = 32'(GATE_CYC / 10);
            2'h2: gate_len = 32'(GATE_CYC / 100);
            default: gate_len = 32'(GATE_CYC);
        endcase
    end

    always_ff @(posedge aclk) begin
        logic [31:0] d;
        logic [1:0] k;
        d = 32'h0;
        k = fcfg_reg[FCFG_AVG_LSB +: 2];
        if (!aresetn) begin
            gate_cnt_reg <= 32'h0;
            for (int i = 0; i < NDI; i++) begin
                prev_reg[i] <= 32'h0;
                frq_reg[i] <= 32'h0;
            end
        end else if (ce) begin
            if (gate_cnt_reg >= gate_len - 32'h1) begin
                gate_cnt_reg <= 32'h0;
                for (int i = 0; i < NDI; i++) begin
                    d = cnt_reg[i] - prev_reg[i];
                    if (fcfg_reg[FCFG_SCAN_LSB +: 2] == 2'h1) d = d * 32'd10;
                    if (fcfg_reg[FCFG_SCAN_LSB +: 2] == 2'h2) d = d * 32'd100;
                    prev_reg[i] <= cnt_reg[i];
                    // Running average, weight 1, 1/2, 1/4 or 1/8 on the new sample
                    frq_reg[i] <= frq_reg[i] - (frq_reg[i] >> k) + (d >> k); // see [R7]
                end
            end else begin
                gate_cnt_reg <= gate_cnt_reg + 32'h1;
            end
        end
    end

    // Host silence watchdog; timeout of zero disables it
    assign wdt_fire = ce && wdt_to_reg != 32'h0 && !wdt_fired_reg && !host_msg && wdt_cnt_reg == wdt_to_reg - 32'h1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_cnt_reg <= 32'h0;
            wdt_fired_reg <= 1'b0;
        end else if (ce) begin
            if (host_msg) begin
                wdt_cnt_reg <= 32'h0; // see [R12]
                wdt_fired_reg <= 1'b0;
            end else if (wdt_fire) begin
                wdt_fired_reg <= 1'b1;
            end else if (!wdt_fired_reg && wdt_to_reg != 32'h0) begin
                wdt_cnt_reg <= wdt_cnt_reg + 32'h1;
            end
        end
    end

    // Remote input polling; one request outstanding at a time
    assign pair_hit = ce && pair_wait_reg && pair_ack;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_cnt_reg <= 32'h0;
            pair_wait_reg <= 1'b0;
            pair_req_reg <= 1'b0;
        end else if (ce) begin
            pair_req_reg <= 1'b0;
            if (pair_hit) begin
                pair_wait_reg <= 1'b0;
            end else if (pair_en_reg && !pair_wait_reg) begin
                if (pair_cnt_reg >= 32'(PAIR_POLL_CYC) - 32'h1) begin
                    pair_cnt_reg <= 32'h0;
                    pair_req_reg <= 1'b1; // see [R11]
                    pair_wait_reg <= 1'b1;
                end else begin
                    pair_cnt_reg <= pair_cnt_reg + 32'h1;
                end
            end
        end
    end

    // Output value: host write, then fallback, then pairing, then mirror
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            do_base_reg <= DO_PWRON_RST; // see [R1]
        end else if (ce) begin
            if (wr_go && awaddr == A_DO && wstrb[0]) begin
                do_base_reg <= wdata[NDO-1:0];
            end else if (wdt_fire) begin
                do_base_reg <= safe_reg; // see [R2]
            end else begin
                for (int i = 0; i < NDO; i++) begin
                    case (dcl_mir_t'(mirror_reg[2*i +: 2]))
                        MIR_LEVEL: do_base_reg[i] <= di_s_reg[i]; // see [R8]
                        MIR_RISE: if (rise[i]) do_base_reg[i] <= 1'b1; // see [R9]
                        MIR_FALL: if (fall[i]) do_base_reg[i] <= 1'b1; // see [R10]
                        default: ;
                    endcase
                    if (pair_hit && pair_mask_reg[i]) do_base_reg[i] <= pair_level; // see [R11]
                end
            end
        end
    end

    // Pulse generators on a shared 10 us tick
    assign tick = tick_cnt_reg == 16'(PWM_TICK_CYC - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg <= 16'h0;
        end else if (ce) begin
            tick_cnt_reg <= tick ? 16'h0 : tick_cnt_reg + 16'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NDO; i++) begin
                ph_reg[i] <= PH_HI;
                pcnt_reg[i] <= 16'h0;
            end
        end else if (ce) begin
            for (int i = 0; i < NDO; i++) begin
                if (!pwm_en_reg[i]) begin
                    ph_reg[i] <= PH_HI;
                    pcnt_reg[i] <= 16'h0;
                end else if (tick) begin
                    case (ph_reg[i])
                        PH_HI: begin
                            if ({1'b0, pcnt_reg[i]} + 17'h1 >= {1'b0, pwm_cfg_reg[i][15:0]}) begin
                                ph_reg[i] <= PH_LO; // see [R4]
                                pcnt_reg[i] <= 16'h0;
                            end else begin
                                pcnt_reg[i] <= pcnt_reg[i] + 16'h1;
                            end
                        end
                        PH_LO: begin
                            if ({1'b0, pcnt_reg[i]} + 17'h1 >= lo_len(pwm_cfg_reg[i])) begin
                                ph_reg[i] <= PH_HI; // see [R4]
                                pcnt_reg[i] <= 16'h0;
                            end else begin
                                pcnt_reg[i] <= pcnt_reg[i] + 16'h1;
                            end
                        end
                        default: ph_reg[i] <= PH_HI;
                    endcase
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NDO; i++) begin
            pwm_lvl[i] = ph_reg[i] == PH_HI && pwm_cfg_reg[i][15:0] != 16'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            do_out_reg <= DO_PWRON_RST; // see [R1]
        end else if (ce) begin
            do_out_reg <= (pwm_en_reg & pwm_lvl) | (~pwm_en_reg & do_base_reg); // see [R3]
        end
    end

    // Interrupts: write one to clear, a new event wins over the clear
    assign ievt = {ce && gate_cnt_reg >= gate_len - 32'h1, pair_hit, wdt_fire};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            if (wr_go && awaddr == A_ISTAT && wstrb[0]) begin
                istat_reg <= (istat_reg & ~wdata[NIRQ-1:0]) | ievt;
            end else begin
                istat_reg <= istat_reg | ievt;
            end
            irq_reg <= |(istat_reg & imask_reg);
        end
    end

    sequence s_pair_ask;
        pair_req_reg;
    endsequence
    sequence s_pair_answer;
        pair_hit && pair_mask_reg[0] && !(wr_go && awaddr == A_DO) && !wdt_fire;
    endsequence

    chk_pwron_level: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> do_out_reg == DO_PWRON_RST && do_base_reg == DO_PWRON_RST) // see [R1]
        else $error("outputs not at power-on level after reset");
    chk_wdt_safe_out: assert property (wdt_fire |=> do_base_reg == $past(safe_reg) ##1 istat_reg[IRQ_WDT]) // see [R2]
        else $error("fallback did not apply safe level");
    chk_pwm_on_time: assert property (pwm_en_reg[0] && ph_reg[0] == PH_HI && pwm_cfg_reg[0][15:0] != 16'h0
        |-> pcnt_reg[0] < pwm_cfg_reg[0][15:0]) // see [R4]
        else $error("on-time ran past its setting");
    chk_cnt_step: assert property (ce && rise[0] |=> cnt_reg[0] == $past(cnt_reg[0]) + 32'h1) // see [R5]
        else $error("counter missed a transition");
    chk_latch_set: assert property (ce && di_s_reg[1] |=> lat_hi_reg[1]) // see [R6]
        else $error("seen-high flag not set");
    chk_latch_clear: assert property (rd_go && araddr == A_LLO && di_s_reg[0] |=> !lat_lo_reg[0]) // see [R13]
        else $error("seen-low flag not cleared by read");
    chk_mirror_level: assert property (ce && mirror_reg[1:0] == MIR_LEVEL && !(wr_go && awaddr == A_DO)
        && !wdt_fire && !(pair_hit && pair_mask_reg[0]) |=> do_base_reg[0] == $past(di_s_reg[0])) // see [R8]
        else $error("level mirror did not follow input");
    chk_mirror_rise: assert property (ce && mirror_reg[1:0] == MIR_RISE && rise[0] && !(wr_go && awaddr == A_DO)
        && !wdt_fire && !(pair_hit && pair_mask_reg[0]) |=> do_base_reg[0]) // see [R9]
        else $error("rising mirror did not switch on");
    chk_mirror_fall: assert property (ce && mirror_reg[1:0] == MIR_FALL && fall[0] && !(wr_go && awaddr == A_DO)
        && !wdt_fire && !(pair_hit && pair_mask_reg[0]) |=> do_base_reg[0]) // see [R10]
        else $error("falling mirror did not switch on");
    chk_pair_write: assert property (s_pair_answer |=> do_base_reg[0] == $past(pair_level)) // see [R11]
        else $error("paired output not written");
    chk_pair_single: assert property (s_pair_ask |=> !pair_req_reg throughout pair_wait_reg[*2]
        or !pair_wait_reg) // see [R11]
        else $error("second poll while one outstanding");
    chk_wdt_restart: assert property (host_msg |=> wdt_cnt_reg == 32'h0 && !wdt_fired_reg) // see [R12]
        else $error("host access did not restart timer");
endmodule : dcl_channel_top

//--- tb/dcl_pair_model.sv
// Remote input client model: answers each poll with the remote level.
// Assumes pair_req is a one-cycle pulse; latency alternates short and long.
`timescale 1ns/1ns
module dcl_pair_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pair_req,
    input wire logic level,
    output logic pair_ack,
    output logic pair_level
);
    logic busy;
    logic slow;
    logic [3:0] cnt;
    always @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            slow <= 1'b0;
            pair_ack <= 1'b0;
            pair_level <= 1'b0;
        end else if (busy && cnt == 4'h0 && !pair_req) begin
            busy <= 1'b0;
            pair_ack <= 1'b1;
            pair_level <= level;
        end else begin
            // Level is only meaningful with ack, so it toggles otherwise
            pair_ack <= 1'b0;
            pair_level <= ~pair_level;
            busy <= busy || pair_req;
            slow <= slow ^ pair_req;
            cnt <= pair_req ? (slow ? 4'h6 : 4'h1) : cnt - 4'h1;
        end
    end
endmodule : dcl_pair_model

//--- tb/testbench.sv
// Self-checking bench for the channel block over AXI4-Lite.
// Assumes the pair model answers every poll; shortened gate and poll counts.
`timescale 1ns/1ns
module testbench;
    import dcl_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, lvl = 1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'hf, di_pin = 4'h0, do_out;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, pair_req, pair_ack, pair_level, irq;
    int fail_count = 0, n_compared = 0;
    dcl_channel_top #(.GATE_CYC(1000), .PAIR_POLL_CYC(20)) i_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .di_pin, .do_out, .pair_req, .pair_ack, .pair_level, .irq);
    dcl_pair_model i_pair (.aclk, .aresetn, .pair_req, .level(lvl), .pair_ack, .pair_level);
    initial forever #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0; wvalid <= 1'b0;
        while (bvalid !== 1'b1) @(posedge aclk);
        rs = bresp; bready <= 1'b0;
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata; rs = rresp; rready <= 1'b0;
    endtask : rdw
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    task automatic t_boot;
        chk(do_out, 32'h0, "power-on level");
        wr(8'hfc, 32'h1);
        chk(rs, RESP_SLVERR, "unmapped write");
        rdw(A_DO);
        chk(rd, 32'h0, "output readback");
        chk(rs, RESP_OKAY, "read ok");
        rdw(8'hf0);
        chk(rs, RESP_SLVERR, "unmapped read");
        chk(rd, 32'h0, "unmapped data");
        $display("boot test done");
    endtask : t_boot
    task automatic t_mirror;
        // ch0 level, ch1 rising, ch2 falling
        wr(A_MIRROR, 32'h39);
        di_pin <= 4'h7;
        cyc(6);
        chk(do_out[2:0], 32'h3, "mirror after rise");
        rdw(A_LLO);
        chk(rd, 32'hf, "seen low kept");
        di_pin <= 4'h0;
        cyc(6);
        chk(do_out[2:0], 32'h6, "mirror after fall");
        rdw(A_LHI);
        chk(rd, 32'h7, "seen high kept");
        rdw(A_LHI);
        chk(rd, 32'h0, "seen high cleared");
        rdw(A_CNT0 + 8'h04);
        chk(rd, 32'h1, "edge count");
        wr(A_MIRROR, 32'h0);
        wr(A_DO, 32'h0);
        $display("mirror test done");
    endtask : t_mirror
    task automatic t_wdt;
        wr(A_SAFE, 32'h5);
        wr(A_IMASK, 32'h1);
        wr(A_WDT, 32'd300);
        repeat (2) begin
            cyc(200);
            rdw(A_DI);
        end
        chk(do_out, 32'h0, "timer restarted");
        cyc(320);
        chk(do_out, 32'h5, "fallback level");
        chk(irq, 32'h1, "irq raised");
        wr(A_WDT, 32'h0);
        wr(A_ISTAT, 32'h1);
        cyc(3);
        chk(irq, 32'h0, "irq cleared");
        $display("watchdog test done");
    endtask : t_wdt
    task automatic t_pair;
        wr(A_DO, 32'h0);
        wr(A_PAIR, 32'h31);
        cyc(80);
        chk(do_out, 32'h3, "pair high");
        chk(irq, 32'h0, "masked irq low");
        lvl <= 1'b0;
        cyc(80);
        chk(do_out, 32'h0, "pair low");
        rdw(A_ISTAT);
        chk(rd[1], 32'h1, "pair status set");
        wr(A_PAIR, 32'h0);
        $display("pair test done");
    endtask : t_pair
    task automatic t_pwm;
        // On-time two ticks, so the first tick never ends it; off-time stretched
        wr(A_PWM0, 32'h2);
        wr(A_PWM_EN, 32'h1);
        cyc(2);
        chk(do_out, 32'h1, "pulse on");
        cyc(2001);
        chk(do_out, 32'h0, "pulse off");
        wr(A_PWM_EN, 32'h0);
        $display("pulse test done");
    endtask : t_pwm
    task automatic t_freq;
        // Input 3 period 20 cycles: 5 rises per 100, 50 per 1000
        fork
            repeat (500) begin
                cyc(10);
                di_pin[3] <= ~di_pin[3];
            end
            begin
                wr(A_FCFG, 32'h5);
                cyc(2000);
                rdw(A_FRQ0 + 8'h0c);
                chk(rd, 32'd50, "averaged frequency");
                wr(A_FCFG, 32'h0);
                cyc(2100);
                rdw(A_FRQ0 + 8'h0c);
                chk(rd, 32'd50, "1 s frequency");
            end
        join
        $display("frequency test done");
    endtask : t_freq
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    initial begin
        cyc(20);
        aresetn <= 1'b1;
        t_boot();
        t_mirror();
        t_wdt();
        t_pair();
        t_pwm();
        t_freq();
        conclude();
    end
    initial begin
        cyc(20000);
        fail_count++;
        conclude();
    end
endmodule : testbench
